/* File: verilog/uhsm_pkg.sv */
// package of the high-speed link state monitor: states, boost codes, chirp timing
// assumes a 250 MHz local sampling clock
package uhsm_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ = 250;
    localparam int CHIRP_MIN_US = 18;
    localparam int CHIRP_MAX_US = 128;
    localparam int CHIRP_MIN_CYC = CHIRP_MIN_US * CLK_MHZ;
    localparam int CHIRP_MAX_CYC = CHIRP_MAX_US * CLK_MHZ;
    localparam int CNT_W = 16;

    // ************************************************************
    // boost level codes
    // ************************************************************
    localparam logic [1:0] BOOST_LVL0 = 2'h0;
    localparam logic [1:0] BOOST_MIN = 2'h3;

    // ************************************************************
    // link states
    // ************************************************************
    typedef enum logic [5:0] {
        ST_UNCONN = 6'b00_0001,
        ST_ATTACH = 6'b00_0010,
        ST_CHIRP_J = 6'b00_0100,
        ST_CHIRP_K = 6'b00_1000,
        ST_HS_WAIT = 6'b01_0000,
        ST_HS = 6'b10_0000
    } uhsm_state_e;

    // line-state observations from the analog front end, either port
    typedef struct packed {
        logic pullup_seen;
        logic disconnect;
        logic suspend;
        logic bus_reset;
        logic chirp_j;
        logic chirp_k;
        logic squelch;
        logic fixture_seen;
        logic test_packet;
    } uhsm_line_s;

    // boost pin sense: level pins valid, floating flag
    typedef struct packed {
        logic floating;
        logic [1:0] level;
    } uhsm_boost_s;

    typedef struct packed {
        uhsm_state_e state;
        uhsm_line_s line_meta;
        uhsm_line_s line_sync;
        logic [CNT_W-1:0] chirp_cnt;
        logic chirp_ok;
        logic sample_pend;
        logic [1:0] boost;
        logic hs_flag;
        logic attach_flag;
        logic en_d;
    } uhsm_reg_s;

endpackage

/* File: verilog/uhsm_link_monitor.sv */
// link state monitor of a two-port high-speed signal conditioner
// assumes line detections come from an analog front end, port-agnostic
`timescale 1ns/1ps
`default_nettype none

module uhsm_link_monitor #(
    parameter int CHIRP_MIN_CYC = uhsm_pkg::CHIRP_MIN_CYC,
    parameter int CHIRP_MAX_CYC = uhsm_pkg::CHIRP_MAX_CYC
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic clk_en_in,
    input wire logic chip_disable_n_in,
    input wire uhsm_pkg::uhsm_boost_s boost_level_select_in,
    input wire uhsm_pkg::uhsm_line_s port_a_line_in,
    input wire uhsm_pkg::uhsm_line_s port_b_line_in,
    output logic high_speed_active_flag_out,
    output logic attach_detect_flag_out,
    output logic core_regulator_output_out,
    output logic hs_boost_enable_out,
    output logic [1:0] boost_level_out
);

    // ************************************************************
    // state
    // ************************************************************
    uhsm_pkg::uhsm_reg_s cur_ff;
    uhsm_pkg::uhsm_reg_s nxt_ff;
    uhsm_pkg::uhsm_line_s line_any;
    logic [uhsm_pkg::CNT_W-1:0] cnt_inc;
    logic chirp_in_win;

    assign line_any = port_a_line_in | port_b_line_in;
    assign cnt_inc = cur_ff.chirp_cnt + {{(uhsm_pkg::CNT_W-1){1'b0}}, 1'b1};
    assign chirp_in_win = (32'(cur_ff.chirp_cnt) >= CHIRP_MIN_CYC) && (32'(cur_ff.chirp_cnt) <= CHIRP_MAX_CYC);

    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.line_meta = line_any;
        nxt_ff.line_sync = cur_ff.line_meta;
        nxt_ff.en_d = chip_disable_n_in;
        if (chip_disable_n_in && !cur_ff.en_d) begin
            nxt_ff.sample_pend = 1'b1;
        end
        if (cur_ff.sample_pend && chip_disable_n_in) begin
            nxt_ff.sample_pend = 1'b0;
            if (boost_level_select_in.floating) begin
                nxt_ff.boost = uhsm_pkg::BOOST_MIN;
            end else begin
                nxt_ff.boost = boost_level_select_in.level;
            end
        end
        if (cur_ff.chirp_cnt != {uhsm_pkg::CNT_W{1'b1}}) begin
            nxt_ff.chirp_cnt = cnt_inc;
        end
        case (cur_ff.state)
            uhsm_pkg::ST_UNCONN: begin
                if (cur_ff.line_sync.pullup_seen) begin
                    nxt_ff.attach_flag = 1'b1;
                    nxt_ff.state = uhsm_pkg::ST_ATTACH;
                end
                if (cur_ff.line_sync.fixture_seen) begin
                    nxt_ff.state = uhsm_pkg::ST_HS_WAIT;
                    nxt_ff.chirp_ok = 1'b0;
                end
            end
            uhsm_pkg::ST_ATTACH: begin
                if (cur_ff.line_sync.bus_reset && cur_ff.line_sync.chirp_j) begin
                    nxt_ff.state = uhsm_pkg::ST_CHIRP_J;
                    nxt_ff.chirp_cnt = '0;
                end
            end
            uhsm_pkg::ST_CHIRP_J: begin
                if (!cur_ff.line_sync.chirp_j) begin
                    if (cur_ff.line_sync.chirp_k && chirp_in_win) begin
                        nxt_ff.state = uhsm_pkg::ST_CHIRP_K;
                        nxt_ff.chirp_cnt = '0;
                    end else begin
                        nxt_ff.state = uhsm_pkg::ST_ATTACH;
                    end
                end
            end
            uhsm_pkg::ST_CHIRP_K: begin
                if (!cur_ff.line_sync.chirp_k) begin
                    nxt_ff.chirp_ok = chirp_in_win;
                    nxt_ff.state = chirp_in_win ? uhsm_pkg::ST_HS_WAIT : uhsm_pkg::ST_ATTACH;
                end
            end
            uhsm_pkg::ST_HS_WAIT: begin
                if (!cur_ff.chirp_ok && cur_ff.line_sync.test_packet) begin
                    nxt_ff.state = uhsm_pkg::ST_HS;
                    nxt_ff.hs_flag = 1'b1;
                end
                if (cur_ff.chirp_ok && cur_ff.line_sync.squelch) begin
                    nxt_ff.state = uhsm_pkg::ST_HS;
                    nxt_ff.hs_flag = 1'b1;
                end
            end
            uhsm_pkg::ST_HS: begin
                if (cur_ff.line_sync.suspend) begin
                    nxt_ff.hs_flag = 1'b0;
                    nxt_ff.chirp_ok = 1'b0;
                    nxt_ff.state = uhsm_pkg::ST_ATTACH;
                end
            end
            default: begin
                nxt_ff.state = uhsm_pkg::ST_UNCONN;
            end
        endcase
        if (cur_ff.line_sync.disconnect && cur_ff.state != uhsm_pkg::ST_UNCONN) begin
            nxt_ff.attach_flag = 1'b0;
            nxt_ff.hs_flag = 1'b0;
            nxt_ff.chirp_ok = 1'b0;
            nxt_ff.state = uhsm_pkg::ST_UNCONN;
        end
        if (!chip_disable_n_in) begin
            nxt_ff.state = uhsm_pkg::ST_UNCONN;
            nxt_ff.hs_flag = 1'b0;
            nxt_ff.attach_flag = 1'b0;
            nxt_ff.chirp_ok = 1'b0;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cur_ff <= '0;
            cur_ff.state <= uhsm_pkg::ST_UNCONN;
            cur_ff.boost <= uhsm_pkg::BOOST_MIN;
            cur_ff.sample_pend <= 1'b1;
        end else if (clk_en_in) begin
            cur_ff <= nxt_ff;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // flags gated by enable
    assign high_speed_active_flag_out = cur_ff.hs_flag & chip_disable_n_in;
    assign attach_detect_flag_out = cur_ff.attach_flag & chip_disable_n_in;
    assign core_regulator_output_out = cur_ff.hs_flag & chip_disable_n_in;
    assign hs_boost_enable_out = cur_ff.hs_flag & chip_disable_n_in;
    assign boost_level_out = cur_ff.boost;

endmodule

`default_nettype wire

/* File: sim/uhsm_line_partner.sv */
// line-state model of the host and device transceivers on either port
// assumes the bench picks the line event and the port that carries it
`timescale 1ns/1ps
`default_nettype none
module uhsm_line_partner (
    input wire uhsm_pkg::uhsm_line_s ev_in,
    input wire logic on_b_in,
    output var uhsm_pkg::uhsm_line_s port_a_out,
    output var uhsm_pkg::uhsm_line_s port_b_out
);
    // ************************************************************
    // port steering
    // ************************************************************
    // the quiet port shows no line activity
    assign port_a_out = on_b_in ? '0 : ev_in;
    assign port_b_out = on_b_in ? ev_in : '0;
endmodule
`default_nettype wire

/* File: sim/uhsm_link_monitor_properties.sv */
// checker of the link monitor flags against its line and disable inputs
// assumes binding to the monitor's top module, one clock domain
`timescale 1ns/1ps
`default_nettype none
module uhsm_link_monitor_chk (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic clk_en_in,
    input wire logic chip_disable_n_in,
    input wire uhsm_pkg::uhsm_line_s port_a_line_in,
    input wire uhsm_pkg::uhsm_line_s port_b_line_in,
    input wire logic high_speed_active_flag_out,
    input wire logic attach_detect_flag_out,
    input wire logic core_regulator_output_out,
    input wire logic hs_boost_enable_out,
    input wire logic [1:0] boost_level_out
);
    // ************************************************************
    // properties
    // ************************************************************
    uhsm_pkg::uhsm_line_s ln;
    assign ln = port_a_line_in | port_b_line_in;
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    sequence s_held(logic b);
        (b && clk_en_in)[*3];
    endsequence
    chk_reg_hs_only: assert property (core_regulator_output_out == high_speed_active_flag_out)
        else $error("regulator enable differs from high speed flag");
    chk_boost_hs_only: assert property (hs_boost_enable_out == high_speed_active_flag_out)
        else $error("boost enable differs from high speed flag");
    chk_off_flags_low: assert property (!chip_disable_n_in |-> !high_speed_active_flag_out && !attach_detect_flag_out)
        else $error("flag high while disabled");
    chk_boost_level_held: assert property (s_held(chip_disable_n_in) |=> $stable(boost_level_out))
        else $error("boost level changed while running");
    chk_reset_values: assert property (disable iff (1'b0) srst_in |=> boost_level_out == uhsm_pkg::BOOST_MIN
        && !attach_detect_flag_out && !high_speed_active_flag_out) else $error("wrong values after reset");
    chk_attach_cause: assert property ($rose(attach_detect_flag_out) && $past(chip_disable_n_in)
        |-> $past(ln.pullup_seen, 3)) else $error("attach flag rose without pull-up");
    chk_hs_cause: assert property ($rose(high_speed_active_flag_out) && $past(chip_disable_n_in)
        |-> $past(ln.squelch || ln.test_packet, 3)) else $error("high speed flag rose without cause");
    chk_hs_clear: assert property (s_held(ln.disconnect || ln.suspend) |=> !high_speed_active_flag_out)
        else $error("high speed flag kept through disconnect or suspend");
    chk_attach_clear: assert property (s_held(ln.disconnect) |=> !attach_detect_flag_out)
        else $error("attach flag kept through disconnect");
endmodule
`default_nettype wire

/* File: sim/uhsm_link_monitor_tb_top.sv */
// self-checking bench of the link monitor with a line partner model
// assumes package, design, partner and checker compiled before it
`timescale 1ns/1ps
`default_nettype none
module uhsm_link_monitor_tb_top;
    // ************************************************************
    // stimulus and checking
    // ************************************************************
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic dis_n = 1'b1;
    logic clk_en = 1'b1;
    logic on_b = 1'b0;
    uhsm_pkg::uhsm_boost_s boost = '0;
    uhsm_pkg::uhsm_line_s ev = '0;
    uhsm_pkg::uhsm_line_s la;
    uhsm_pkg::uhsm_line_s lb;
    logic hs, att, reg_en, boost_en;
    logic [1:0] lvl;
    logic [1:0] want;
    logic [3:0] st;
    integer seed = 32'hd54d;
    integer failures = 0;
    integer tests_run = 0;
    integer len;
    assign st = {hs, att, reg_en, boost_en};
    always #2 clk_in = ~clk_in;
    uhsm_line_partner i_partner (.ev_in(ev), .on_b_in(on_b), .port_a_out(la), .port_b_out(lb));
    uhsm_link_monitor #(.CHIRP_MIN_CYC(10), .CHIRP_MAX_CYC(40)) i_dut (.clk_in(clk_in), .srst_in(srst_in),
        .clk_en_in(clk_en), .chip_disable_n_in(dis_n), .boost_level_select_in(boost), .port_a_line_in(la),
        .port_b_line_in(lb), .high_speed_active_flag_out(hs), .attach_detect_flag_out(att),
        .core_regulator_output_out(reg_en), .hs_boost_enable_out(boost_en), .boost_level_out(lvl));
    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic hold(input logic [8:0] pat, input integer n);
        ev = pat;
        repeat (n) @(negedge clk_in);
    endtask
    function automatic logic [1:0] exp_boost(input uhsm_pkg::uhsm_boost_s b);
        return b.floating ? uhsm_pkg::BOOST_MIN : b.level;
    endfunction
    task automatic results;
        $display("tests %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        boost.level = 2'($random(seed));
        want = exp_boost(boost);
        repeat (3) @(negedge clk_in);
        srst_in = 1'b0;
        hold(9'h000, 4);
        chk({2'h0, lvl}, {2'h0, want});
        boost.level = ~boost.level;
        hold(9'h000, 4);
        chk({2'h0, lvl}, {2'h0, want});
        // attach, good and bad handshakes on both ports
        for (int k = 0; k < 2; k++) begin
            on_b = k[0];
            hold(9'h100, 6);
            chk(st, 4'h4);
            len = 15 + ($random(seed) & 15);
            hold(9'h030, len);
            hold(9'h008, len);
            hold(9'h004, 6);
            chk(st, 4'hf);
            hold(9'h040, 6);
            chk(st, 4'h4);
            hold(9'h030, 4 + k * 50);
            hold(9'h008, 20);
            hold(9'h004, 6);
            chk(st, 4'h4);
            hold(9'h080, 6);
            chk(st, 4'h0);
        end
        hold(9'h002, 6);
        hold(9'h001, 6);
        chk(st, 4'hb);
        dis_n = 1'b0;
        #1;
        chk(st, 4'h0);
        boost.floating = 1'b1;
        hold(9'h000, 4);
        dis_n = 1'b1;
        hold(9'h000, 6);
        chk(st, 4'h0);
        chk({2'h0, lvl}, {2'h0, exp_boost(boost)});
        // frozen clock enable must hold off the attach detection
        clk_en = 1'b0;
        hold(9'h100, 6);
        chk(st, 4'h0);
        clk_en = 1'b1;
        hold(9'h100, 6);
        chk(st, 4'h4);
        results();
    end
endmodule
bind uhsm_link_monitor uhsm_link_monitor_chk i_chk (.clk_in, .srst_in, .clk_en_in, .chip_disable_n_in,
    .port_a_line_in, .port_b_line_in, .high_speed_active_flag_out, .attach_detect_flag_out,
    .core_regulator_output_out, .hs_boost_enable_out, .boost_level_out);
`default_nettype wire
